// >>> design/hdcr_regs.svh
// offsets, field positions and reset values of the device feature config register
`ifndef HDCR_REGS_SVH
`define HDCR_REGS_SVH
`define HDCR_CFG_OFFSET 8'h05
`define HDCR_BIT_STR_WE 7
`define HDCR_BIT_SER_WE 6
`define HDCR_BIT_LPM_DIS 5
`define HDCR_BIT_RSVD4 4
`define HDCR_BIT_GANGED 3
`define HDCR_BIT_RPT_N 2
`define HDCR_BIT_RSVD1 1
`define HDCR_BIT_RSVD0 0
`define HDCR_CFG_RESET 8'h10
`define HDCR_NUM_PORTS 4
`endif

// >>> design/hdcr_pkg.sv
// types shared by the device feature config register
package hdcr_pkg;
  typedef logic [7:0] hdcr_byte_t;
  typedef logic [3:0] hdcr_ports_t;
  typedef enum logic [1:0] {
    hdcr_st_reset = 2'b00,
    hdcr_st_strap = 2'b01,
    hdcr_st_run   = 2'b10
  } hdcr_state_e;
endpackage

// >>> design/hdcr_config.sv
// device feature config register of a four-port hub, with strap capture and gates
`timescale 1ns/100ps
`include "hdcr_regs.svh"
module hdcr_config
  import hdcr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // register port (SMBus slave or EEPROM loader side)
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_from_eeprom,
  input wire logic i2c_mode,
  output logic [7:0] reg_rdata,
  // protected string register write requests
  input wire logic string_write_req,
  input wire logic serial_write_req,
  output logic string_write_grant,
  output logic serial_write_grant,
  // link power management
  input wire logic force_accept_lmp,
  input wire logic upstream_disconnect,
  output logic link_low_power_allow,
  // strap pins
  input wire logic power_scheme_strap_pin,
  input wire logic status_report_strap_pin,
  // port power
  input wire logic [3:0] port_power_request,
  output logic [3:0] port_power_control_pins,
  output logic power_status_report_en
);

  hdcr_state_e state_reg, state_next;
  logic string_write_enable;
  logic serial_string_write_enable;
  logic link_low_power_disable;
  logic power_scheme_ganged;
  logic power_status_report_n;
  logic rsvd_rw_bit;
  logic force_seen_reg;
  logic [2:0] scheme_sync_reg;
  logic [2:0] report_sync_reg;
  logic scheme_level_reg;
  logic report_level_reg;
  // reset pattern as a byte; string_write_enable takes its bit by position, the other fields reset to zero
  localparam hdcr_byte_t cfg_reset_value = `HDCR_CFG_RESET;

  // decode of the register port
  wire cfg_hit = reg_addr == `HDCR_CFG_OFFSET;
  // eeprom loads only in i2c mode, host writes only in smbus mode
  wire src_ok = reg_from_eeprom ? i2c_mode : !i2c_mode;
  wire cfg_wr = clock_enable && reg_write && cfg_hit && src_ok &&
                state_reg == hdcr_st_run;
  wire strap_take = state_reg == hdcr_st_strap;

  // assembled read value, reserved bits 4 and 0 fixed, reserved bit 1 read/write
  wire [7:0] cfg_value = {string_write_enable, serial_string_write_enable,
                          link_low_power_disable, 1'b1,
                          power_scheme_ganged, power_status_report_n,
                          rsvd_rw_bit, 1'b0};

  // strap pins cross in by three flops; change counts when last two agree
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      scheme_sync_reg <= 3'h0;
      report_sync_reg <= 3'h0;
      scheme_level_reg <= 1'b0;
      report_level_reg <= 1'b0;
    end else if (clock_enable) begin
      scheme_sync_reg <= {scheme_sync_reg[1:0], power_scheme_strap_pin};
      report_sync_reg <= {report_sync_reg[1:0], status_report_strap_pin};
      if (scheme_sync_reg[2] == scheme_sync_reg[1]) begin
        scheme_level_reg <= scheme_sync_reg[2];
      end
      if (report_sync_reg[2] == report_sync_reg[1]) begin
        report_level_reg <= report_sync_reg[2];
      end
    end
  end

  // sequencer: wait for synchroniser to fill, then latch straps once
  always_comb begin
    case (state_reg)
      hdcr_st_reset: state_next = hdcr_st_strap;
      hdcr_st_strap: state_next = hdcr_st_run;
      hdcr_st_run: state_next = hdcr_st_run;
      default: state_next = hdcr_st_reset;
    endcase
  end

  // next-state logic alone leaves the reset state after one cycle; the strap filter needs three to settle,
  // so the sequencer counts those before the latch
  logic [1:0] settle_reg;
  wire settle_done = settle_reg == 2'h3;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      settle_reg <= 2'h0;
      state_reg <= hdcr_st_reset;
    end else if (clock_enable) begin
      if (!settle_done) begin
        settle_reg <= settle_reg + 2'h1;
      end
      if (settle_done || state_reg != hdcr_st_reset) begin
        state_reg <= state_next;
      end
    end
  end

  // configuration bits
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      string_write_enable <= cfg_reset_value[`HDCR_BIT_STR_WE];
      serial_string_write_enable <= 1'b0;
      link_low_power_disable <= 1'b0;
      power_scheme_ganged <= 1'b0;
      power_status_report_n <= 1'b0;
      rsvd_rw_bit <= 1'b0;
    end else if (strap_take && clock_enable) begin
      power_scheme_ganged <= scheme_level_reg;
      power_status_report_n <= report_level_reg;
    end else if (cfg_wr) begin
      string_write_enable <= reg_wdata[`HDCR_BIT_STR_WE];
      serial_string_write_enable <= reg_wdata[`HDCR_BIT_SER_WE];
      link_low_power_disable <= reg_wdata[`HDCR_BIT_LPM_DIS];
      power_scheme_ganged <= reg_wdata[`HDCR_BIT_GANGED];
      power_status_report_n <= reg_wdata[`HDCR_BIT_RPT_N];
      rsvd_rw_bit <= reg_wdata[`HDCR_BIT_RSVD1];
    end
  end

  // forced accept sticks until reset or upstream disconnect
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      force_seen_reg <= 1'b0;
    end else if (clock_enable) begin
      if (force_accept_lmp) begin
        force_seen_reg <= 1'b1;
      end else if (upstream_disconnect) begin
        force_seen_reg <= 1'b0;
      end
    end
  end

  // port power: ganged follows port 1 request on all pins
  wire [3:0] power_next = power_scheme_ganged ? {4{port_power_request[0]}} :
                          port_power_request;
  wire lpm_allow_next = !link_low_power_disable || force_seen_reg || force_accept_lmp;

  // registered outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      string_write_grant <= 1'b0;
      serial_write_grant <= 1'b0;
      link_low_power_allow <= 1'b0;
      port_power_control_pins <= 4'h0;
      power_status_report_en <= 1'b0;
    end else if (clock_enable) begin
      // unmapped reads answer zero
      reg_rdata <= (reg_read && cfg_hit) ? cfg_value : 8'h00;
      string_write_grant <= string_write_req && string_write_enable;
      serial_write_grant <= serial_write_req && serial_string_write_enable;
      link_low_power_allow <= lpm_allow_next;
      port_power_control_pins <= power_next;
      power_status_report_en <= !power_status_report_n;
    end
  end

  // checks
  rsvd_bits_a: assert property (@(posedge clock) disable iff (reset)
    reg_read && cfg_hit && clock_enable |=> reg_rdata[4] && !reg_rdata[0])
    else $error("reserved bits read wrong");
  str_grant_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !string_write_enable |=> !string_write_grant)
    else $error("string write granted while locked");
  ser_grant_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !serial_string_write_enable |=> !serial_write_grant)
    else $error("serial write granted while locked");
  lpm_block_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && link_low_power_disable && !force_seen_reg && !force_accept_lmp
    |=> !link_low_power_allow)
    else $error("u1u2 allowed while disabled");
  force_hold_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && force_accept_lmp ##1 clock_enable |=> link_low_power_allow)
    else $error("forced accept not honoured");
  gang_pins_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && power_scheme_ganged |=> &port_power_control_pins ||
    ~|port_power_control_pins)
    else $error("ganged pins differ");
  report_en_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable |=> power_status_report_en == !$past(power_status_report_n))
    else $error("report enable wrong");
  strap_cap_a: assert property (@(posedge clock) disable iff (reset)
    strap_take && clock_enable |=> power_scheme_ganged == $past(scheme_level_reg) &&
    power_status_report_n == $past(report_level_reg))
    else $error("strap not captured");
  cfg_write_a: assert property (@(posedge clock) disable iff (reset)
    cfg_wr |=> string_write_enable == $past(reg_wdata[7]))
    else $error("config write lost");

  // multi-step checks, some built from the named sequences below
  // the settle count ends while still in the reset state
  sequence settle_end_s;
    clock_enable && settle_done && state_reg == hdcr_st_reset;
  endsequence

  // the one cycle in which the strap levels are latched
  sequence strap_step_s;
    clock_enable && state_reg == hdcr_st_strap;
  endsequence

  // an accepted write to the config byte
  sequence cfg_write_s;
    cfg_wr;
  endsequence

  // a read of the config byte with no write in the same cycle
  sequence cfg_read_s;
    clock_enable && reg_read && cfg_hit && !cfg_wr;
  endsequence

  // a disconnect with no forced accept beside it
  sequence drop_only_s;
    clock_enable && upstream_disconnect && !force_accept_lmp;
  endsequence

  // latch comes exactly one step after the filter has settled
  strap_order_a: assert property (@(posedge clock) disable iff (reset)
    settle_end_s |=> state_reg == hdcr_st_strap)
    else $error("strap latch out of order");

  // the latch is taken once; afterwards only writes move the bits
  strap_once_a: assert property (@(posedge clock) disable iff (reset)
    strap_step_s |=> state_reg == hdcr_st_run)
    else $error("strap state not left");

  // a write followed by a read returns bits 7 and 5 as written
  write_read_a: assert property (@(posedge clock) disable iff (reset)
    cfg_write_s ##1 cfg_read_s |=> reg_rdata[7] == $past(reg_wdata[7], 2) &&
    reg_rdata[5] == $past(reg_wdata[5], 2))
    else $error("config readback wrong");

  // writes from the wrong source are dropped silently
  src_refuse_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && reg_write && cfg_hit && !src_ok |=> $stable(link_low_power_disable))
    else $error("wrong source write landed");

  // writes before the run state cannot move the gate bits
  early_write_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && reg_write && state_reg != hdcr_st_run |=> $stable(string_write_enable))
    else $error("write landed before run");

  // a low enable freezes the configuration bits
  freeze_hold_a: assert property (@(posedge clock) disable iff (reset)
    !clock_enable |=> $stable(string_write_enable) && $stable(link_low_power_disable))
    else $error("state moved while frozen");

  // disconnect alone ends the forced accept
  force_clear_a: assert property (@(posedge clock) disable iff (reset)
    drop_only_s |=> !force_seen_reg)
    else $error("forced accept not cleared");

  // per-port scheme passes each request to its own pin
  per_port_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !power_scheme_ganged |=>
    port_power_control_pins == $past(port_power_request))
    else $error("per-port pins wrong");

  // an open gate lets the request through one cycle later
  grant_open_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && string_write_enable && string_write_req |=> string_write_grant)
    else $error("string write not granted");

  // low power stays allowed while it is not disabled
  lpm_open_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !link_low_power_disable |=> link_low_power_allow)
    else $error("u1u2 blocked while enabled");

  // anything but a config read answers zero
  unmapped_read_a: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !(reg_read && cfg_hit) |=> reg_rdata == 8'h00)
    else $error("idle read data not zero");

  // limitation: the strap filter assumes straps are steady well before release;
  // a strap that toggles during the settle count is latched at its last
  // agreed level, not at the level seen at the release edge itself

endmodule // hdcr_config

// >>> sim/hdcr_host_model.sv
// smbus host and eeprom loader model for the config register port
`timescale 1ns/100ps
module hdcr_host_model (
  // clock
  input wire logic clock,
  // register port
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_from_eeprom,
  input wire logic [7:0] reg_rdata
);
  // idle bus, address parked away from the register
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'hff;
    reg_wdata = 8'h00;
    reg_from_eeprom = 1'b0;
  end
  // one write; bit 1 always sent as its default
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic src);
    @(posedge clock) #1;
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d & 8'hfd;
    reg_from_eeprom = src;
    @(posedge clock) #1;
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata; // released data must not look valid
  endtask
  // one read; data is registered, so it is taken one edge after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) #1;
    reg_read = 1'b1;
    reg_addr = a;
    @(posedge clock) #1;
    reg_read = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule // hdcr_host_model

// >>> sim/hdcr_config_tb.sv
// self-checking bench for the device feature config register
`timescale 1ns/100ps
`include "hdcr_regs.svh"
module hdcr_config_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clock_enable = 1'b1;
  logic i2c_mode = 1'b0;
  logic force_accept_lmp = 1'b0;
  logic upstream_disconnect = 1'b0;
  logic [3:0] port_power_request = 4'h0;
  logic reg_write, reg_read, reg_from_eeprom, sw_g, ser_g, lp_ok, rpt_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic [3:0] pins;
  int errors = 0;
  int n_checks = 0;
  // 100 MHz clock
  always #5 clock = ~clock;
  // straps: scheme high, report low; both string requests held
  hdcr_config u_hdcr_config (.clock(clock), .reset(reset), .clock_enable(clock_enable),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_from_eeprom(reg_from_eeprom), .i2c_mode(i2c_mode), .reg_rdata(reg_rdata),
    .string_write_req(1'b1), .serial_write_req(1'b1), .string_write_grant(sw_g),
    .serial_write_grant(ser_g), .force_accept_lmp(force_accept_lmp),
    .upstream_disconnect(upstream_disconnect), .link_low_power_allow(lp_ok),
    .power_scheme_strap_pin(1'b1), .status_report_strap_pin(1'b0),
    .port_power_request(port_power_request), .port_power_control_pins(pins),
    .power_status_report_en(rpt_en));
  hdcr_host_model u_hdcr_host_model (.clock(clock), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_from_eeprom(reg_from_eeprom), .reg_rdata(reg_rdata));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog, far beyond the roughly 56 cycles the tests need
  initial begin
    #50000;
    errors++;
    test_done();
  end
  // main sequence; writes start well after the strap latch
  initial begin
    repeat (20) @(posedge clock);
    #1 reset = 1'b0;
    repeat (8) @(posedge clock);
    u_hdcr_host_model.rd(`HDCR_CFG_OFFSET, rd);
    chk("cfg reset", 8'h18, rd);
    port_power_request = 4'h1;
    u_hdcr_host_model.rd(8'h06, rd);
    chk("unmapped", 8'h00, rd);
    chk("grants", 8'h00, {6'h0, sw_g, ser_g});
    chk("lp allow", 8'h01, {7'h0, lp_ok});
    chk("ganged pins", 8'h0f, {4'h0, pins});
    chk("report en", 8'h01, {7'h0, rpt_en});
    $display("test reset done");
    u_hdcr_host_model.wr(`HDCR_CFG_OFFSET, 8'he1, 1'b0);
    port_power_request = 4'h5;
    u_hdcr_host_model.wr(8'h06, 8'h00, 1'b0);
    u_hdcr_host_model.wr(`HDCR_CFG_OFFSET, 8'h00, 1'b1);
    u_hdcr_host_model.rd(`HDCR_CFG_OFFSET, rd);
    chk("host write", 8'hf0, rd);
    chk("grants on", 8'h03, {6'h0, sw_g, ser_g});
    chk("lp blocked", 8'h00, {7'h0, lp_ok});
    chk("port pins", 8'h05, {4'h0, pins});
    // forced accept reopens low power until disconnect
    force_accept_lmp = 1'b1;
    @(posedge clock) #1 force_accept_lmp = 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("lp forced", 8'h01, {7'h0, lp_ok});
    upstream_disconnect = 1'b1;
    @(posedge clock) #1 upstream_disconnect = 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("lp cleared", 8'h00, {7'h0, lp_ok});
    $display("test host done");
    i2c_mode = 1'b1;
    u_hdcr_host_model.wr(`HDCR_CFG_OFFSET, 8'he0, 1'b0);
    u_hdcr_host_model.wr(`HDCR_CFG_OFFSET, 8'h0c, 1'b1);
    u_hdcr_host_model.rd(`HDCR_CFG_OFFSET, rd);
    chk("eeprom load", 8'h1c, rd);
    chk("grants off", 8'h00, {6'h0, sw_g, ser_g});
    chk("report off", 8'h00, {7'h0, rpt_en});
    chk("lp again", 8'h01, {7'h0, lp_ok});
    chk("ganged again", 8'h0f, {4'h0, pins});
    $display("test eeprom done");
    // a legal load while the enable is low must not land
    clock_enable = 1'b0;
    u_hdcr_host_model.wr(`HDCR_CFG_OFFSET, 8'he0, 1'b1);
    clock_enable = 1'b1;
    u_hdcr_host_model.rd(`HDCR_CFG_OFFSET, rd);
    chk("frozen", 8'h1c, rd);
    $display("test freeze done");
    test_done();
  end
endmodule // hdcr_config_tb
